// >>> clock_gen_pkg.sv
// Register map, field layout, reset values and timing counts of the clock generator block
package clock_gen_pkg;
   // Word indices; byte address is four times the index
   localparam logic [29:0] IDX_CONTROL = 30'h0000_0036;
   localparam logic [29:0] IDX_MULTIPLIER = 30'h0000_0037;
   localparam logic [29:0] IDX_TRIM = 30'h0000_0038;
   localparam logic [29:0] IDX_DIVIDER = 30'h0000_0039;
   localparam logic [29:0] IDX_STAGE = 30'h0000_003A;

   // Control register bit positions
   localparam int BIT_IRQ_ENABLE = 7;
   localparam int BIT_FAIL_FLAG = 6;
   localparam int BIT_MONITOR_ON = 5;
   localparam int BIT_CLOCK_SELECT = 4;
   localparam int BIT_INT_ON = 3;
   localparam int BIT_INT_STABLE = 2;
   localparam int BIT_EXT_ON = 1;
   localparam int BIT_EXT_STABLE = 0;

   // Field widths
   localparam int MULT_W = 7;
   localparam int TRIM_W = 8;
   localparam int DIV_W = 4;
   localparam int STAGE_W = 8;

   // Reset values and the multiplier and divider limits
   localparam logic [6:0] MULT_RESET = 7'h15;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam logic [6:0] MULT_ZERO = 7'h00;
   localparam logic [6:0] MULT_ONE = 7'h01;
   localparam logic [3:0] DIV_MAX = 4'h9;

   // External clock edges before the external source counts as started
   localparam int EXT_STABLE_EDGES = 4096;

   // Number of asynchronous status inputs passed through the filter
   localparam int SYNC_N = 4;
   localparam int SYNC_INT_DEAD = 0;
   localparam int SYNC_EXT_DEAD = 1;
   localparam int SYNC_INT_LOCK = 2;
   localparam int SYNC_EXT_CLK = 3;

   // AHB transfer type and response
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// >>> clock_gen_monitor_regs.sv
// Control and status registers of the clock generator with monitor, on an AHB-Lite slave
//
// Overview of operation
// R1: Monitor interrupt output is high while irq enable and failure flag are both set.
// R2: Irq enable sets only while monitor is on; cleared when monitor off or reset.
// R3: With monitor on, an inactive internal or external clock sets the failure flag.
// R4: Failure flag clears by a read while set followed by a zero write.
// R5: Monitor-on sets only when both generators are on and both are stable.
// R6: Monitor-on is held set while the failure flag is set.
// R7: Monitor-on cleared when a generator is off, in stop without oscillator, or reset.
// R8: Clock select 1 picks the external clock, 0 the internal clock.
// R9: Select sets only with external on and stable; clears only with internal ready.
// R10: Select forced external on internal failure; forced internal on external failure.
// R11: Internal-on clears only with select set and monitor off; else forced set.
// R12: Internal-stable follows lock, cleared on failure, off, factor writes, stop, reset.
// R13: External-on clears only with select and monitor clear; forced set otherwise.
// R14: External-stable sets after 4096 external clock edges since enable.
// R15: Seven-bit multiplier drives the oscillator; zero is treated as one.
// R16: Multiplier ignores writes while monitor is on; reset value is 21.
// R17: Eight-bit trim goes to the oscillator; higher trim means lower frequency.
// R18: Trim ignores writes while monitor is on; reset value is 0x80.
// R19: Divider count follows the loop while internal is on; codes above nine give nine on divider_count.
// R20: Stage count follows the loop while internal on; unwritable then; not reset.
// R21: Stop without the oscillator option halts clocks and disables the monitor.
// R22: Hardware forcing wins over a software write in the same cycle.
`timescale 1ns/100ps
module clock_gen_monitor_regs #(
   parameter int EXT_STABLE_COUNT = clock_gen_pkg::EXT_STABLE_EDGES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic [1:0] hresp,
   // Oscillator and monitor status (asynchronous)
   input wire logic internal_clock_dead,
   input wire logic external_clock_dead,
   input wire logic internal_lock,
   input wire logic external_clock,
   // Loop filter values and power mode (same clock)
   input wire logic [3:0] loop_divider_count,
   input wire logic [7:0] loop_stage_count,
   input wire logic stop_mode,
   input wire logic osc_run_in_stop,
   // Outputs to the analog clock generator and the CPU
   output logic monitor_irq,
   output logic osc_out_select,
   output logic internal_gen_enable,
   output logic external_gen_enable,
   output logic clocks_halted,
   output logic [6:0] multiplier_factor,
   output logic [7:0] trim_factor,
   output logic [3:0] divider_count,
   output logic [7:0] stage_count
);

   localparam int CNT_W = $clog2(EXT_STABLE_COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(EXT_STABLE_COUNT);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // Elaboration-time check of the start-up count
   if (EXT_STABLE_COUNT < 1) begin : g_bad_count
      $error("EXT_STABLE_COUNT must be at least one");
   end

   // Control state
   logic monitor_irq_enable;
   logic monitor_fail_flag;
   logic monitor_on;
   logic clock_select;
   logic internal_gen_on;
   logic internal_gen_stable;
   logic external_gen_on;
   logic external_gen_stable;
   logic fail_flag_armed;
   logic [6:0] mult_reg;
   logic [7:0] trim_reg;
   logic [3:0] div_reg;
   logic [7:0] stage_reg;
   logic [CNT_W-1:0] ext_edges;

   // Bus state
   logic wr_pend;
   logic [29:0] wr_idx;
   logic rd_wait;
   logic [29:0] rd_idx;

   // Input filter state
   logic [2:0] sync_q [clock_gen_pkg::SYNC_N];
   logic [clock_gen_pkg::SYNC_N-1:0] filt;
   logic ext_clk_prev;

   // Three-stage synchronisers; a change counts once stages two and three agree
   for (genvar i = 0; i < clock_gen_pkg::SYNC_N; i++) begin : g_sync
      wire logic raw_in;
      if (i == clock_gen_pkg::SYNC_INT_DEAD) begin : g_a
         assign raw_in = internal_clock_dead;
      end else if (i == clock_gen_pkg::SYNC_EXT_DEAD) begin : g_b
         assign raw_in = external_clock_dead;
      end else if (i == clock_gen_pkg::SYNC_INT_LOCK) begin : g_c
         assign raw_in = internal_lock;
      end else begin : g_d
         assign raw_in = external_clock;
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            sync_q[i] <= 3'h0;
            filt[i] <= 1'b0;
         end else begin
            sync_q[i] <= {sync_q[i][1:0], raw_in};
            if (sync_q[i][1] == sync_q[i][2]) begin
               filt[i] <= sync_q[i][2];
            end
         end
      end
   end

   wire logic int_dead = filt[clock_gen_pkg::SYNC_INT_DEAD];
   wire logic ext_dead = filt[clock_gen_pkg::SYNC_EXT_DEAD];
   wire logic int_lock = filt[clock_gen_pkg::SYNC_INT_LOCK];
   wire logic ext_rise = filt[clock_gen_pkg::SYNC_EXT_CLK] & ~ext_clk_prev;

   // Bus address phase and data phase decode
   wire logic addr_ok = hsel & hready & (htrans == clock_gen_pkg::HTRANS_NONSEQ);
   wire logic accept_wr = addr_ok & hwrite;
   wire logic accept_rd = addr_ok & ~hwrite;
   wire logic [29:0] word_addr = haddr[31:2];
   wire logic [7:0] wdat = hwdata[7:0];
   wire logic wr_ctrl = wr_pend & (wr_idx == clock_gen_pkg::IDX_CONTROL);
   wire logic wr_mult = wr_pend & (wr_idx == clock_gen_pkg::IDX_MULTIPLIER);
   wire logic wr_trim = wr_pend & (wr_idx == clock_gen_pkg::IDX_TRIM);
   wire logic wr_div = wr_pend & (wr_idx == clock_gen_pkg::IDX_DIVIDER);
   wire logic wr_stage = wr_pend & (wr_idx == clock_gen_pkg::IDX_STAGE);
   // A read following a write waits a cycle so it never returns stale data
   wire logic rd_now = accept_rd & ~wr_pend;
   wire logic rd_late = rd_wait;
   wire logic [29:0] rd_sel = rd_late ? rd_idx : word_addr;
   wire logic rd_ctrl_now = (rd_now | rd_late) & (rd_sel == clock_gen_pkg::IDX_CONTROL);

   // Written control bits
   wire logic w_ie = wdat[clock_gen_pkg::BIT_IRQ_ENABLE];
   wire logic w_ff = wdat[clock_gen_pkg::BIT_FAIL_FLAG];
   wire logic w_mon = wdat[clock_gen_pkg::BIT_MONITOR_ON];
   wire logic w_cs = wdat[clock_gen_pkg::BIT_CLOCK_SELECT];
   wire logic w_ion = wdat[clock_gen_pkg::BIT_INT_ON];
   wire logic w_eon = wdat[clock_gen_pkg::BIT_EXT_ON];

   // Stop without the oscillator option halts everything
   wire logic halted = stop_mode & ~osc_run_in_stop; // see R21
   // Monitor only judges clocks while on and running
   wire logic mon_live = monitor_on & ~halted; // see R21
   wire logic int_fail = mon_live & int_dead;
   wire logic ext_fail = mon_live & ext_dead;
   wire logic all_ready = internal_gen_on & external_gen_on
                        & internal_gen_stable & external_gen_stable;

   // Monitor-on: clear forcing first, then hold by flag, then software
   wire logic mon_force_clr = ~internal_gen_on | ~external_gen_on | halted; // see R7
   wire logic next_monitor_on = mon_force_clr ? 1'b0 : // see R22
                                monitor_fail_flag ? 1'b1 : // see R6
                                wr_ctrl ? (w_mon & (monitor_on | all_ready)) : // see R5
                                monitor_on;

   // Irq enable needs the monitor already on in the cycle of the write
   wire logic next_irq_enable = ~monitor_on ? 1'b0 : // see R2
                                wr_ctrl ? w_ie : monitor_irq_enable;

   // Failure flag: a set in the clearing cycle wins
   wire logic ff_clear = wr_ctrl & fail_flag_armed & ~w_ff; // see R4
   wire logic next_fail_flag = ~monitor_on ? 1'b0 :
                               (int_fail | ext_fail) ? 1'b1 : // see R3
                               ff_clear ? 1'b0 : monitor_fail_flag;
   // Armed by a control read that sees the flag set
   wire logic next_armed = ~next_fail_flag ? 1'b0 :
                           (rd_ctrl_now & monitor_fail_flag) ? 1'b1 : fail_flag_armed; // see R4

   // Clock select; going internal wins when both sources are forced
   wire logic cs_force_int = ext_fail | ~external_gen_on; // see R10
   wire logic cs_force_ext = int_fail | ~internal_gen_on; // see R10
   wire logic cs_sw = w_cs ? (clock_select | (external_gen_on & external_gen_stable)) :
                      (clock_select & ~(internal_gen_on & internal_gen_stable)); // see R9
   wire logic next_clock_select = cs_force_int ? 1'b0 :
                                  cs_force_ext ? 1'b1 : // see R22
                                  wr_ctrl ? cs_sw : clock_select;

   // Generator enables; a clear is only possible when nothing forces them
   wire logic ion_force = monitor_on | ~clock_select; // see R11
   wire logic next_internal_on = ion_force ? 1'b1 : wr_ctrl ? w_ion : internal_gen_on;
   wire logic eon_force = monitor_on | clock_select; // see R13
   wire logic next_external_on = eon_force ? 1'b1 : wr_ctrl ? w_eon : external_gen_on;

   // Factor writes, refused while the monitor is on
   wire logic mult_take = wr_mult & ~monitor_on; // see R16
   wire logic trim_take = wr_trim & ~monitor_on; // see R18

   // Internal stable follows the lock detector unless knocked down
   wire logic is_clear = int_fail | ~internal_gen_on | mult_take | trim_take | halted;
   wire logic next_int_stable = ~is_clear & int_lock; // see R12

   // External start-up counter restarts whenever the source is knocked down
   wire logic es_clear = ext_fail | ~external_gen_on | halted; // see R14
   wire logic cnt_done = (ext_edges == CNT_LAST);

   // Effective values sent to the oscillator
   wire logic [6:0] mult_eff = (mult_reg == clock_gen_pkg::MULT_ZERO) ?
                               clock_gen_pkg::MULT_ONE : mult_reg; // see R15
   wire logic [3:0] div_eff = (div_reg > clock_gen_pkg::DIV_MAX) ?
                              clock_gen_pkg::DIV_MAX : div_reg; // see R19

   // Read multiplexer, low byte only
   wire logic [7:0] ctrl_rd = {monitor_irq_enable, monitor_fail_flag, monitor_on,
                               clock_select, internal_gen_on, internal_gen_stable,
                               external_gen_on, external_gen_stable};
   wire logic [7:0] rd_byte = (rd_sel == clock_gen_pkg::IDX_CONTROL) ? ctrl_rd :
                              (rd_sel == clock_gen_pkg::IDX_MULTIPLIER) ? {1'b0, mult_reg} :
                              (rd_sel == clock_gen_pkg::IDX_TRIM) ? trim_reg :
                              (rd_sel == clock_gen_pkg::IDX_DIVIDER) ? {4'h0, div_reg} :
                              (rd_sel == clock_gen_pkg::IDX_STAGE) ? stage_reg : 8'h00;

   // Bus pipeline; zero wait states except read right after write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 30'h0000_0000;
         rd_wait <= 1'b0;
         rd_idx <= 30'h0000_0000;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= clock_gen_pkg::HRESP_OKAY;
      end else begin
         wr_pend <= accept_wr;
         wr_idx <= word_addr;
         rd_wait <= accept_rd & wr_pend;
         rd_idx <= word_addr;
         hreadyout <= ~(accept_rd & wr_pend);
         if (rd_now | rd_late) begin
            hrdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         monitor_irq_enable <= 1'b0;
         monitor_fail_flag <= 1'b0;
         fail_flag_armed <= 1'b0;
         monitor_on <= 1'b0;
         clock_select <= 1'b0;
         internal_gen_on <= 1'b1;
         internal_gen_stable <= 1'b0;
         external_gen_on <= 1'b0;
         external_gen_stable <= 1'b0;
      end else begin
         monitor_irq_enable <= next_irq_enable;
         monitor_fail_flag <= next_fail_flag;
         fail_flag_armed <= next_armed;
         monitor_on <= next_monitor_on;
         clock_select <= next_clock_select;
         internal_gen_on <= next_internal_on;
         internal_gen_stable <= next_int_stable;
         external_gen_on <= next_external_on;
         external_gen_stable <= ~es_clear & (external_gen_stable | cnt_done);
      end
   end

   // External edge counter, saturating at the start-up count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_edges <= '0;
         ext_clk_prev <= 1'b0;
      end else begin
         ext_clk_prev <= filt[clock_gen_pkg::SYNC_EXT_CLK];
         if (es_clear) begin
            ext_edges <= '0;
         end else if (ext_rise & ~cnt_done) begin
            ext_edges <= ext_edges + CNT_ONE; // see R14
         end
      end
   end

   // Multiplier and trim
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mult_reg <= clock_gen_pkg::MULT_RESET; // see R16
         trim_reg <= clock_gen_pkg::TRIM_RESET; // see R18
      end else begin
         if (mult_take) begin
            mult_reg <= wdat[6:0];
         end
         if (trim_take) begin
            trim_reg <= wdat;
         end
      end
   end

   // Oscillator state survives reset; loop filter owns it while internal is on
   always_ff @(posedge hclk) begin
      if (internal_gen_on) begin
         div_reg <= loop_divider_count; // see R19
         stage_reg <= loop_stage_count; // see R20
      end else begin
         if (wr_div) begin
            div_reg <= wdat[3:0];
         end
         if (wr_stage) begin
            stage_reg <= wdat;
         end
      end
   end

   // Registered outputs toward the oscillator and CPU
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         monitor_irq <= 1'b0;
         osc_out_select <= 1'b0;
         internal_gen_enable <= 1'b1;
         external_gen_enable <= 1'b0;
         clocks_halted <= 1'b0;
         multiplier_factor <= clock_gen_pkg::MULT_RESET;
         trim_factor <= clock_gen_pkg::TRIM_RESET;
      end else begin
         monitor_irq <= monitor_irq_enable & monitor_fail_flag; // see R1
         osc_out_select <= clock_select; // see R8
         internal_gen_enable <= internal_gen_on;
         external_gen_enable <= external_gen_on;
         clocks_halted <= halted; // see R21
         multiplier_factor <= mult_eff;
         trim_factor <= trim_reg; // see R17
      end
   end

   // Oscillator readback outputs, unaffected by reset like their source
   always_ff @(posedge hclk) begin
      divider_count <= div_eff;
      stage_count <= stage_reg;
   end

   // Checks on the block's own behaviour
   sequence s_flag_armed;
      fail_flag_armed && monitor_fail_flag;
   endsequence

   sequence s_flag_gone;
      !monitor_fail_flag;
   endsequence

   property p_irq_follows;
      @(posedge hclk) disable iff (!hresetn)
      (monitor_irq_enable && monitor_fail_flag) |=> monitor_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq not raised"); // see R1

   property p_ie_needs_mon;
      @(posedge hclk) disable iff (!hresetn)
      !monitor_on |=> !monitor_irq_enable;
   endproperty
   a_ie_needs_mon: assert property (p_ie_needs_mon) else $error("irq enable without monitor"); // see R2

   property p_fail_sets;
      @(posedge hclk) disable iff (!hresetn)
      (monitor_on && !halted && (int_dead || ext_dead)) |=> monitor_fail_flag;
   endproperty
   a_fail_sets: assert property (p_fail_sets) else $error("failure not flagged"); // see R3

   property p_flag_clear;
      @(posedge hclk) disable iff (!hresetn)
      (monitor_on && $fell(monitor_fail_flag)) |-> $past(fail_flag_armed);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read"); // see R4

   property p_mon_hold;
      @(posedge hclk) disable iff (!hresetn)
      (s_flag_armed or monitor_fail_flag) ##0 (!halted && internal_gen_on && external_gen_on)
      |=> monitor_on;
   endproperty
   a_mon_hold: assert property (p_mon_hold) else $error("monitor dropped with flag set"); // see R6

   property p_mon_off;
      @(posedge hclk) disable iff (!hresetn)
      (!internal_gen_on || !external_gen_on || halted) |=> !monitor_on ##1 s_flag_gone;
   endproperty
   a_mon_off: assert property (p_mon_off) else $error("monitor not forced off"); // see R7

   property p_mon_set;
      @(posedge hclk) disable iff (!hresetn)
      $rose(monitor_on) |-> $past(all_ready);
   endproperty
   a_mon_set: assert property (p_mon_set) else $error("monitor set while not ready"); // see R5

   property p_select_out;
      @(posedge hclk) disable iff (!hresetn)
      $changed(clock_select) |=> (osc_out_select == $past(clock_select));
   endproperty
   a_select_out: assert property (p_select_out) else $error("select output lags"); // see R8

   property p_mult_locked;
      @(posedge hclk) disable iff (!hresetn)
      (wr_mult && monitor_on) |=> $stable(mult_reg);
   endproperty
   a_mult_locked: assert property (p_mult_locked) else $error("multiplier written"); // see R16

   property p_trim_locked;
      @(posedge hclk) disable iff (!hresetn)
      (wr_trim && monitor_on) |=> $stable(trim_reg) ##1 (trim_factor == $past(trim_reg, 2));
   endproperty
   a_trim_locked: assert property (p_trim_locked) else $error("trim written"); // see R18

   property p_stable_drop;
      @(posedge hclk) disable iff (!hresetn)
      mult_take |=> !internal_gen_stable;
   endproperty
   a_stable_drop: assert property (p_stable_drop) else $error("stable kept on write"); // see R12

   property p_ext_count;
      @(posedge hclk) disable iff (!hresetn)
      $rose(external_gen_stable) |-> $past(ext_edges) == CNT_LAST;
   endproperty
   a_ext_count: assert property (p_ext_count) else $error("stable before count"); // see R14

   property p_ion_forced;
      @(posedge hclk) disable iff (!hresetn)
      (monitor_on || !clock_select) |=> internal_gen_on;
   endproperty
   a_ion_forced: assert property (p_ion_forced) else $error("internal on cleared"); // see R11

endmodule

// >>> ext_clock_source.sv
// Behavioural crystal source that feeds the block's external clock input
`timescale 1ns/100ps
module ext_clock_source (
   // Pacing clock
   input wire logic hclk,
   // Oscillator enable from the block
   input wire logic run,
   // Crystal output
   output logic external_clock
);
   logic [1:0] div = 2'h0;
   initial external_clock = 1'b0;
   // Period of eight bus cycles, slow enough for the edge filter; stands low when off
   always @(posedge hclk) begin
      div <= div + 2'h1;
      if (!run) begin
         external_clock <= 1'b0;
      end else if (div == 2'h3) begin
         external_clock <= ~external_clock;
      end
   end
endmodule

// >>> clock_gen_monitor_regs_bench.sv
// Self-checking bench for the clock generator register block
`timescale 1ns/100ps
module clock_gen_monitor_regs_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, monitor_irq, osc_out_select, int_en, ext_en, clocks_halted, ext_clk;
   logic [31:0] hrdata, rd;
   logic [1:0] hresp;
   logic [6:0] multiplier_factor, mval;
   logic [7:0] trim_factor, stage_count, tv;
   logic [3:0] divider_count;
   logic int_dead = 1'b0, lock = 1'b0, stop = 1'b0, run_stop = 1'b0;
   logic [3:0] loop_div = 4'h0;
   logic [7:0] loop_stg = 8'h00;
   int num_errors = 0;
   int n_checks = 0;
   // Free-running bus clock
   always #20 hclk = ~hclk;
   // Short stable count keeps the run brief
   clock_gen_monitor_regs #(.EXT_STABLE_COUNT(8)) clock_gen_monitor_regs_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .internal_clock_dead(int_dead), .external_clock_dead(1'b0), .internal_lock(lock),
      .external_clock(ext_clk), .loop_divider_count(loop_div), .loop_stage_count(loop_stg),
      .stop_mode(stop), .osc_run_in_stop(run_stop), .monitor_irq(monitor_irq),
      .osc_out_select(osc_out_select), .internal_gen_enable(int_en),
      .external_gen_enable(ext_en), .clocks_halted(clocks_halted),
      .multiplier_factor(multiplier_factor), .trim_factor(trim_factor),
      .divider_count(divider_count), .stage_count(stage_count));
   ext_clock_source ext_clock_source_i (.hclk(hclk), .run(ext_en), .external_clock(ext_clk));
   function automatic logic [3:0] clamp_div(input logic [3:0] v);
      return (v > 4'h9) ? 4'h9 : v;
   endfunction
   function automatic logic [6:0] map_mult(input logic [6:0] v);
      return (v == 7'h00) ? 7'h01 : v;
   endfunction
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Wait for ready with no bound of its own; only the watchdog ends a hang
   task automatic wait_rdy;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
   endtask
   // One single-word transfer; read data lands in rd
   task automatic bus(input logic [29:0] idx, input logic wr, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= clock_gen_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      wait_rdy();
      // A write leaves no read data behind, so polling loops never see stale bits
      rd = wr ? 32'h0000_0000 : hrdata;
   endtask
   task automatic rd_chk(input logic [29:0] idx, input logic [31:0] m, input logic [31:0] e);
      bus(idx, 1'b0, 8'h00);
      chk(rd & m, e);
      chk(hresp, clock_gen_pkg::HRESP_OKAY);
   endtask
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      num_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'hb83c));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hFF, 32'h08);
      rd_chk(clock_gen_pkg::IDX_MULTIPLIER, 32'h7F, 32'h15);
      rd_chk(clock_gen_pkg::IDX_TRIM, 32'hFF, 32'h80);
      chk(osc_out_select, 1'b0);
      chk(ext_en, 1'b0);
      chk(int_en, 1'b1);
      // Clearing internal-on or setting select without the other source ready is refused
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'h00);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hFF, 32'h08);
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'h18);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hFF, 32'h08);
      rd_chk(30'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset and refusals done");
      // Random trim, multiplier with zero first, and loop values
      for (int i = 0; i < 4; i++) begin
         tv = 8'($urandom);
         mval = (i == 0) ? 7'h00 : 7'($urandom);
         loop_div <= 4'($urandom);
         loop_stg <= 8'($urandom);
         bus(clock_gen_pkg::IDX_TRIM, 1'b1, tv);
         bus(clock_gen_pkg::IDX_MULTIPLIER, 1'b1, {1'b0, mval});
         rd_chk(clock_gen_pkg::IDX_TRIM, 32'hFF, {24'h00_0000, tv});
         chk(trim_factor, tv);
         chk(multiplier_factor, map_mult(mval));
         chk(divider_count, clamp_div(loop_div));
         chk(stage_count, loop_stg);
      end
      $display("test factors done");
      // Start external source, then the monitor and its interrupt enable
      lock <= 1'b1;
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'h0A);
      repeat (80) if (rd[0] !== 1'b1) bus(clock_gen_pkg::IDX_CONTROL, 1'b0, 8'h00);
      chk(rd[0], 1'b1);
      chk(ext_en, 1'b1);
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'h2A);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hFF, 32'h2F);
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'hAA);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hFF, 32'hAF);
      bus(clock_gen_pkg::IDX_MULTIPLIER, 1'b1, 8'h33);
      bus(clock_gen_pkg::IDX_TRIM, 1'b1, ~tv);
      rd_chk(clock_gen_pkg::IDX_MULTIPLIER, 32'h7F, {25'h0, mval});
      rd_chk(clock_gen_pkg::IDX_TRIM, 32'hFF, {24'h00_0000, tv});
      $display("test monitor start done");
      // Internal clock dies: flag, interrupt, forced select, held monitor
      int_dead <= 1'b1;
      // Filter, flag and output register need six edges
      repeat (8) @(posedge hclk);
      chk(monitor_irq, 1'b1);
      chk(int_en, 1'b1);
      chk(osc_out_select, 1'b1);
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'hC0);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hF0, 32'hF0);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'h20, 32'h20);
      int_dead <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(clock_gen_pkg::IDX_CONTROL, 1'b1, 8'hBF);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'h40, 32'h00);
      chk(monitor_irq, 1'b0);
      $display("test failure done");
      // Stop with and without the oscillator option
      stop <= 1'b1;
      run_stop <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(clocks_halted, 1'b0);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'h20, 32'h20);
      run_stop <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(clocks_halted, 1'b1);
      rd_chk(clock_gen_pkg::IDX_CONTROL, 32'hA0, 32'h00);
      stop <= 1'b0;
      $display("test stop done");
      wrap_up();
   end
endmodule
